// ===== verilog/aec_pkg.sv
// Constants shared by the alarm status and error counter block
// How it works
// [RL1] Transmit alarm bit change pulses its interrupt flag
// [RL2] Deactivate flag follows deactivate code detection
// [RL3] Activate flag follows activate code detection
// [RL4] Driver short flag follows current limit
// [RL5] No transmit edges in 8 references: lost
// [RL6] Four edges in 8 references: present
// [RL7] Transmit frame loss follows transmit framer
// [RL8] Change of alignment loss OR pulses interrupt
// [RL9] Receive alignment bits never frozen by latching
// [RL10] TS16 alarm latches, read clears, CAS only
// [RL11] Severely errored frame latches, read clears
// [RL12] CAS loss shown only when CAS enabled
// [RL13] Multiframe loss shown only when enabled
// [RL14] Frame loss rising edge bumps alarm counter
// [RL15] Cause code latched at each frame loss
// [RL16] Counters wrap if enabled, else saturate
// [RL17] Host reads low byte before high byte
// [RL18] 12-bit framing count, high read clears
// [RL19] 10-bit CRC count, high read clears
// [RL20] 16-bit code violation count, high read clears
// [RL21] Far block count valid only in E1
package aec_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [8:0] ADDR_TX_ALARM  = 9'h048;
	localparam logic [8:0] ADDR_RX_ALIGN  = 9'h049;
	localparam logic [8:0] ADDR_FE_LOW    = 9'h050;
	localparam logic [8:0] ADDR_FE_HIGH   = 9'h051;
	localparam logic [8:0] ADDR_CRC_LOW   = 9'h052;
	localparam logic [8:0] ADDR_CRC_HIGH  = 9'h053;
	localparam logic [8:0] ADDR_LCV_LOW   = 9'h054;
	localparam logic [8:0] ADDR_LCV_HIGH  = 9'h055;
	localparam logic [8:0] ADDR_FAR_BLOCK_ERROR_COUNT_LOW  = 9'h056;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_DEACT   = 7;
	localparam int BIT_ACT     = 6;
	localparam int BIT_SHORT   = 4;
	localparam int BIT_CLKLOST = 3;
	localparam int BIT_TXLOF   = 1;
	localparam int BIT_TS16    = 6;
	localparam int BIT_SEF     = 5;
	localparam int BIT_CASL    = 4;
	localparam int BIT_MFL     = 3;
	localparam int BIT_FRL     = 2;
	// ----------------------------------------
	// Counter widths and overflow enable index
	// ----------------------------------------
	localparam int FE_W   = 12;
	localparam int CRC_W  = 10;
	localparam int LCV_W  = 16;
	localparam int FAR_BLOCK_ERROR_COUNT_W = 10;
	localparam int OVF_FE = 0;
	localparam int OVF_CRC = 1;
	localparam int OVF_LCV = 2;
	localparam int OVF_FAR_BLOCK_ERROR_COUNT = 3;
	// ----------------------------------------
	// Receive framer modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		AEC_MODE_E1  = 2'h0,
		AEC_MODE_FT  = 2'h1,
		AEC_MODE_ESF = 2'h2
	} aec_mode_t;
	// ----------------------------------------
	// Criteria and timing counts
	// ----------------------------------------
	localparam logic [2:0] SEF_WIN_E1   = 3'h6;
	localparam logic [2:0] SEF_WIN_FT   = 3'h3;
	localparam logic [2:0] SEF_WIN_ESF  = 3'h6;
	localparam logic [2:0] SEF_ERR_MIN  = 3'h2;
	localparam logic [2:0] TS16_ZERO_MAX = 3'h3;
	localparam logic [3:0] REF_WIN      = 4'h8;
	localparam logic [2:0] EDGE_PRESENT = 3'h4;
	localparam logic [1:0] LOF_RST      = 2'h0;
endpackage : aec_pkg

// ===== verilog/aec_clk_mon.sv
// Transmit clock monitor referenced to the auxiliary clock
module aec_clk_mon (
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	input  wire logic auxiliary_reference_clock_i,
	input  wire logic transmit_line_clock_i,
	output logic      transmit_clock_lost_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] aux_sy;
		logic [1:0] tx_sy;
		logic       aux_d;
		logic       tx_d;
		logic [3:0] ref_cnt;
		logic [2:0] edge_cnt;
		logic       lost;
	} aec_mon_t;
	aec_mon_t st_r;
	aec_mon_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.aux_sy = {st_r.aux_sy[0], auxiliary_reference_clock_i};
		st_nxt.tx_sy  = {st_r.tx_sy[0], transmit_line_clock_i};
		st_nxt.aux_d  = st_r.aux_sy[1];
		st_nxt.tx_d   = st_r.tx_sy[1];
		if ((st_r.tx_sy[1] != st_r.tx_d) && (st_r.edge_cnt != aec_pkg::EDGE_PRESENT))
			st_nxt.edge_cnt = st_r.edge_cnt + 3'h1;
		if (st_r.aux_sy[1] && !st_r.aux_d) begin
			if (st_r.ref_cnt == aec_pkg::REF_WIN - 4'h1) begin
				st_nxt.ref_cnt  = 4'h0;
				st_nxt.edge_cnt = 3'h0;
				if (st_r.edge_cnt == 3'h0)
					st_nxt.lost = 1'b1; // [RL5]
				else if (st_r.edge_cnt >= aec_pkg::EDGE_PRESENT)
					st_nxt.lost = 1'b0; // [RL6]
			end else begin
				st_nxt.ref_cnt = st_r.ref_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign transmit_clock_lost_o = st_r.lost;
endmodule : aec_clk_mon

// ===== verilog/aec_status_counters.sv
// Alarm status registers and performance error counters
module aec_status_counters (
	input  wire logic        core_clk_i,
	input  wire logic        rst_b_i,
	// Register port
	input  wire logic [8:0]  reg_addr_i,
	input  wire logic        reg_rd_i,
	output logic [7:0]       reg_rdata_o,
	// Transmit side status
	input  wire logic        loopback_deactivate_detect_i,
	input  wire logic        loopback_activate_detect_i,
	input  wire logic        driver_short_flag_i,
	input  wire logic        transmit_frame_loss_i,
	input  wire logic        auxiliary_reference_clock_i,
	input  wire logic        transmit_line_clock_i,
	// Receive alignment machines
	input  wire logic        basic_frame_alignment_loss_i,
	input  wire logic        multiframe_alignment_loss_i,
	input  wire logic        cas_alignment_loss_i,
	input  wire logic [1:0]  frame_loss_cause_i,
	input  wire logic        cas_enable_i,
	input  wire logic        mfas_enable_i,
	input  wire logic [1:0]  receive_mode_i,
	input  wire logic        frame_bit_check_i,
	input  wire logic        frame_bit_error_i,
	input  wire logic        ts16_bit_valid_i,
	input  wire logic        ts16_bit_i,
	input  wire logic        multiframe_start_i,
	// Error events and counter control
	input  wire logic        framing_error_i,
	input  wire logic        crc_error_i,
	input  wire logic        bipolar_violation_i,
	input  wire logic        excess_zeros_i,
	input  wire logic        excess_zeros_count_en_i,
	input  wire logic        far_block_error_i,
	input  wire logic        e1_mode_i,
	input  wire logic [3:0]  counter_overflow_enables_i,
	input  wire logic        count_latch_enable_i,
	input  wire logic        one_second_tick_i,
	// Interrupt status and alarm counter events
	output logic [4:0]       transmit_alarm_interrupt_status_o,
	output logic             receive_alarm_interrupt_status_o,
	output logic             frame_loss_count_inc_o,
	output logic             severely_errored_count_inc_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] cnt_step(input logic [15:0] v, input logic [15:0] max,
			input logic inc, input logic wrap);
		logic [15:0] r;
		r = v;
		if (inc) begin
			if (v != max)
				r = v + 16'h0001;
			else if (wrap)
				r = 16'h0000; // [RL16]
		end
		return r;
	endfunction : cnt_step

	function automatic logic [2:0] ones6(input logic [5:0] v, input logic [2:0] win);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 6; i++)
			if (i < int'(win) && v[i])
				n = n + 3'h1;
		return n;
	endfunction : ones6

	localparam logic [15:0] FE_MAX   = 16'({aec_pkg::FE_W{1'b1}});
	localparam logic [15:0] CRC_MAX  = 16'({aec_pkg::CRC_W{1'b1}});
	localparam logic [15:0] LCV_MAX  = 16'({aec_pkg::LCV_W{1'b1}});
	localparam logic [15:0] FAR_BLOCK_ERROR_COUNT_MAX = 16'({aec_pkg::FAR_BLOCK_ERROR_COUNT_W{1'b1}});

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [4:0]  tx_alm;
		logic [4:0]  tx_int;
		logic        rx_int;
		logic        fr_loss;
		logic        mf_loss;
		logic        cas_loss;
		logic        or_prev;
		logic        fr_inc;
		logic        sef_inc;
		logic        severely_errored_frame_flag;
		logic        ts16;
		logic [1:0]  frame_loss_cause;
		logic [5:0]  hist;
		logic [2:0]  zeros;
		logic        low_mf;
		logic [15:0] fe;
		logic [15:0] crc;
		logic [15:0] code_violation_count_low;
		logic [15:0] far_block_error_count;
		logic [15:0] fe_s;
		logic [15:0] crc_s;
		logic [15:0] lcv_s;
		logic [15:0] far_block_error_count_s;
		logic [7:0]  rdata;
	} aec_state_t;
	aec_state_t st_r;
	aec_state_t st_nxt;
	logic       clk_lost;
	logic [4:0] tx_now;
	logic       or_now;
	logic [2:0] sef_win;
	logic [2:0] sef_cnt;
	logic       lcv_ev;
	logic       rd_high_clr;

	// ----------------------------------------
	// Transmit clock monitor
	// ----------------------------------------
	aec_clk_mon u_clk_mon (
		.core_clk_i                  (core_clk_i),
		.rst_b_i                     (rst_b_i),
		.auxiliary_reference_clock_i (auxiliary_reference_clock_i),
		.transmit_line_clock_i       (transmit_line_clock_i),
		.transmit_clock_lost_o       (clk_lost)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		// Live transmit alarms: deact, act, short, clock lost, frame loss
		tx_now = {loopback_deactivate_detect_i, loopback_activate_detect_i,
			driver_short_flag_i, clk_lost, transmit_frame_loss_i}; // [RL2] [RL3] [RL4] [RL7]
		st_nxt.tx_alm = tx_now;
		st_nxt.tx_int = tx_now ^ st_r.tx_alm; // [RL1]

		// Receive alignment, never frozen by one second latching
		st_nxt.fr_loss  = basic_frame_alignment_loss_i; // [RL9]
		st_nxt.mf_loss  = multiframe_alignment_loss_i & mfas_enable_i; // [RL13]
		st_nxt.cas_loss = cas_alignment_loss_i & cas_enable_i; // [RL12]
		or_now = st_nxt.fr_loss | st_nxt.mf_loss | st_nxt.cas_loss;
		st_nxt.or_prev = or_now;
		st_nxt.rx_int  = or_now ^ st_r.or_prev; // [RL8]
		st_nxt.fr_inc  = basic_frame_alignment_loss_i & ~st_r.fr_loss; // [RL14]
		if (basic_frame_alignment_loss_i && !st_r.fr_loss)
			st_nxt.frame_loss_cause = frame_loss_cause_i; // [RL15]

		// Latched alarms: read clears first, a new event wins
		if (reg_rd_i && reg_addr_i == aec_pkg::ADDR_RX_ALIGN) begin
			st_nxt.severely_errored_frame_flag  = 1'b0; // [RL11]
			st_nxt.ts16 = 1'b0; // [RL10]
		end

		// Severely errored frame over a sliding window of framing bits
		unique case (receive_mode_i)
			aec_pkg::AEC_MODE_FT:  sef_win = aec_pkg::SEF_WIN_FT;
			aec_pkg::AEC_MODE_ESF: sef_win = aec_pkg::SEF_WIN_ESF;
			default:               sef_win = aec_pkg::SEF_WIN_E1;
		endcase
		sef_cnt = 3'h0;
		st_nxt.sef_inc = 1'b0;
		if (frame_bit_check_i) begin
			st_nxt.hist = {st_r.hist[4:0], frame_bit_error_i};
			sef_cnt = ones6(st_nxt.hist, sef_win);
			if (frame_bit_error_i && sef_cnt >= aec_pkg::SEF_ERR_MIN) begin
				st_nxt.severely_errored_frame_flag     = 1'b1; // [RL11]
				st_nxt.sef_inc = 1'b1;
			end
		end

		// TS16 zero density per multiframe, two in a row latch
		if (!cas_enable_i) begin
			st_nxt.ts16   = 1'b0; // [RL10]
			st_nxt.zeros  = 3'h0;
			st_nxt.low_mf = 1'b0;
		end else if (multiframe_start_i) begin
			st_nxt.zeros  = 3'h0;
			st_nxt.low_mf = st_r.zeros <= aec_pkg::TS16_ZERO_MAX;
			if (st_nxt.low_mf && st_r.low_mf)
				st_nxt.ts16 = 1'b1; // [RL10]
		end else if (ts16_bit_valid_i && !ts16_bit_i && st_r.zeros != 3'h7) begin
			st_nxt.zeros = st_r.zeros + 3'h1;
		end

		// Counters: high byte read clears unless latching, event wins
		rd_high_clr = reg_rd_i && !count_latch_enable_i;
		if (rd_high_clr && reg_addr_i == aec_pkg::ADDR_FE_HIGH)
			st_nxt.fe = 16'h0000; // [RL18]
		if (rd_high_clr && reg_addr_i == aec_pkg::ADDR_CRC_HIGH)
			st_nxt.crc = 16'h0000; // [RL19]
		if (rd_high_clr && reg_addr_i == aec_pkg::ADDR_LCV_HIGH)
			st_nxt.code_violation_count_low = 16'h0000; // [RL20]
		if (count_latch_enable_i && one_second_tick_i) begin
			st_nxt.fe_s   = st_r.fe;
			st_nxt.crc_s  = st_r.crc;
			st_nxt.lcv_s  = st_r.code_violation_count_low;
			st_nxt.far_block_error_count_s = st_r.far_block_error_count;
			st_nxt.fe     = 16'h0000;
			st_nxt.crc    = 16'h0000;
			st_nxt.code_violation_count_low    = 16'h0000;
			st_nxt.far_block_error_count   = 16'h0000;
		end
		lcv_ev = bipolar_violation_i | (excess_zeros_i & excess_zeros_count_en_i); // [RL20]
		st_nxt.fe = cnt_step(st_nxt.fe, FE_MAX, framing_error_i,
			counter_overflow_enables_i[aec_pkg::OVF_FE]); // [RL16] [RL18]
		st_nxt.crc = cnt_step(st_nxt.crc, CRC_MAX, crc_error_i,
			counter_overflow_enables_i[aec_pkg::OVF_CRC]); // [RL16] [RL19]
		st_nxt.code_violation_count_low = cnt_step(st_nxt.code_violation_count_low, LCV_MAX, lcv_ev,
			counter_overflow_enables_i[aec_pkg::OVF_LCV]); // [RL16] [RL20]
		st_nxt.far_block_error_count = cnt_step(st_nxt.far_block_error_count, FAR_BLOCK_ERROR_COUNT_MAX, far_block_error_i & e1_mode_i,
			counter_overflow_enables_i[aec_pkg::OVF_FAR_BLOCK_ERROR_COUNT]); // [RL21]

		// Registered read data
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				aec_pkg::ADDR_TX_ALARM: st_nxt.rdata = {st_r.tx_alm[4], st_r.tx_alm[3], 1'b0,
					st_r.tx_alm[2], st_r.tx_alm[1], 1'b0, st_r.tx_alm[0], 1'b0};
				aec_pkg::ADDR_RX_ALIGN: st_nxt.rdata = {1'b0, st_r.ts16, st_r.severely_errored_frame_flag,
					st_r.cas_loss, st_r.mf_loss, st_r.fr_loss, st_r.frame_loss_cause};
				aec_pkg::ADDR_FE_LOW:  st_nxt.rdata = count_latch_enable_i ?
					st_r.fe_s[7:0] : st_r.fe[7:0];
				aec_pkg::ADDR_FE_HIGH: st_nxt.rdata = count_latch_enable_i ?
					{4'h0, st_r.fe_s[11:8]} : {4'h0, st_r.fe[11:8]};
				aec_pkg::ADDR_CRC_LOW:  st_nxt.rdata = count_latch_enable_i ?
					st_r.crc_s[7:0] : st_r.crc[7:0];
				aec_pkg::ADDR_CRC_HIGH: st_nxt.rdata = count_latch_enable_i ?
					{6'h00, st_r.crc_s[9:8]} : {6'h00, st_r.crc[9:8]};
				aec_pkg::ADDR_LCV_LOW:  st_nxt.rdata = count_latch_enable_i ?
					st_r.lcv_s[7:0] : st_r.code_violation_count_low[7:0];
				aec_pkg::ADDR_LCV_HIGH: st_nxt.rdata = count_latch_enable_i ?
					st_r.lcv_s[15:8] : st_r.code_violation_count_low[15:8];
				aec_pkg::ADDR_FAR_BLOCK_ERROR_COUNT_LOW: st_nxt.rdata = count_latch_enable_i ?
					st_r.far_block_error_count_s[7:0] : st_r.far_block_error_count[7:0];
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r     <= '0;
			st_r.frame_loss_cause <= aec_pkg::LOF_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata_o                       = st_r.rdata;
	assign transmit_alarm_interrupt_status_o = st_r.tx_int;
	assign receive_alarm_interrupt_status_o  = st_r.rx_int;
	assign frame_loss_count_inc_o            = st_r.fr_inc;
	assign severely_errored_count_inc_o      = st_r.sef_inc;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_tx_change_int;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_r.tx_alm != $past(st_r.tx_alm))
			|-> (transmit_alarm_interrupt_status_o == (st_r.tx_alm ^ $past(st_r.tx_alm)));
	endproperty
	a_tx_change_int: assert property (p_tx_change_int) else $error("tx alarm change lost"); // [RL1]

	property p_deact_follow;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		loopback_deactivate_detect_i |=> st_r.tx_alm[4];
	endproperty
	a_deact_follow: assert property (p_deact_follow) else $error("deactivate flag stale"); // [RL2]

	property p_short_follow;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		!driver_short_flag_i |=> !st_r.tx_alm[2];
	endproperty
	a_short_follow: assert property (p_short_follow) else $error("short flag stale"); // [RL4]

	property p_rx_int;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		$changed(st_r.or_prev) |-> receive_alarm_interrupt_status_o;
	endproperty
	a_rx_int: assert property (p_rx_int) else $error("rx loss change missed"); // [RL8]

	property p_ts16_noncas;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		!cas_enable_i |=> !st_r.ts16 && !st_r.cas_loss;
	endproperty
	a_ts16_noncas: assert property (p_ts16_noncas) else $error("cas bits set off"); // [RL10]

	property p_sef_read;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(reg_rd_i && reg_addr_i == aec_pkg::ADDR_RX_ALIGN && !frame_bit_check_i)
			|=> !st_r.severely_errored_frame_flag;
	endproperty
	a_sef_read: assert property (p_sef_read) else $error("sef not cleared"); // [RL11]

	property p_fr_inc;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		$rose(st_r.fr_loss) |-> frame_loss_count_inc_o ##1 !frame_loss_count_inc_o;
	endproperty
	a_fr_inc: assert property (p_fr_inc) else $error("frame loss count missed"); // [RL14]

	property p_lof_hold;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		!$rose(st_r.fr_loss) |-> $stable(st_r.frame_loss_cause);
	endproperty
	a_lof_hold: assert property (p_lof_hold) else $error("cause code moved"); // [RL15]

	property p_crc_sat;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_r.crc == CRC_MAX && !counter_overflow_enables_i[aec_pkg::OVF_CRC] && !reg_rd_i
			&& !one_second_tick_i) |=> st_r.crc == CRC_MAX;
	endproperty
	a_crc_sat: assert property (p_crc_sat) else $error("crc count not held"); // [RL16]

	property p_fe_clear;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(reg_rd_i && reg_addr_i == aec_pkg::ADDR_FE_HIGH && !count_latch_enable_i
			&& !framing_error_i) |=> st_r.fe == 16'h0000;
	endproperty
	a_fe_clear: assert property (p_fe_clear) else $error("framing count not cleared"); // [RL18]

	property p_crc_wrap;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(st_r.crc == CRC_MAX && counter_overflow_enables_i[aec_pkg::OVF_CRC] && crc_error_i
			&& !reg_rd_i && !one_second_tick_i) |=> st_r.crc == 16'h0000;
	endproperty
	a_crc_wrap: assert property (p_crc_wrap) else $error("crc count not wrapped"); // [RL16]

	property p_act_follow;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		loopback_activate_detect_i |=> st_r.tx_alm[3];
	endproperty
	a_act_follow: assert property (p_act_follow) else $error("activate flag stale"); // [RL3]

	property p_mf_gate;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		!mfas_enable_i |=> !st_r.mf_loss;
	endproperty
	a_mf_gate: assert property (p_mf_gate) else $error("multiframe loss shown off"); // [RL13]

	property p_lof_capture;
		@(posedge core_clk_i) disable iff (!rst_b_i)
		$rose(st_r.fr_loss) |-> st_r.frame_loss_cause == $past(frame_loss_cause_i);
	endproperty
	a_lof_capture: assert property (p_lof_capture) else $error("cause code not taken"); // [RL15]
endmodule : aec_status_counters

// ===== testbench/aec_host.sv
// Host processor model that reads the register port
module aec_host (
	input  wire logic       core_clk_i,
	input  wire logic [7:0] reg_rdata_i,
	output logic      [8:0] reg_addr_o,
	output logic            reg_rd_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		reg_addr_o = 9'h1FF;
		reg_rd_o   = 1'b0;
	end

	// One read: strobe held over one edge, data taken once it has settled
	task automatic rd8(input logic [8:0] a, output logic [7:0] d);
		@(negedge core_clk_i);
		reg_addr_o = a;
		reg_rd_o   = 1'b1;
		@(negedge core_clk_i);
		reg_rd_o   = 1'b0;
		reg_addr_o = ~a;
		@(negedge core_clk_i);
		d = reg_rdata_i;
	endtask : rd8

	// Counter read: low byte always first
	task automatic rd16(input logic [8:0] a, output logic [15:0] d);
		logic [7:0] lo;
		logic [7:0] hi;
		rd8(a, lo);
		rd8(a + 9'h001, hi);
		d = {hi, lo};
	endtask : rd16
endmodule : aec_host

// ===== testbench/tb.sv
// Self-checking bench for the alarm status and error counter block
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic        core_clk_i, rst_b_i, aux_clk, tx_clk, tx_run, reg_rd;
	logic [8:0]  reg_addr;
	logic [7:0]  rdata, d8;
	logic [15:0] d16;
	logic        deact, act, short_flag, tx_lof, basic, mfl, casl, cas_en, mfas_en;
	logic [1:0]  cause, mode;
	logic        fb_chk, fb_err, ts_vld, ts_bit, mf_start, e1, latch_en, tick;
	logic        fe_ev, crc_ev, bpv_ev, exz_ev, far_block_error_count_ev, exz_en;
	logic [3:0]  ovf_en;
	logic [4:0]  tx_int;
	logic        rx_int, lof_inc, sef_inc;
	int          bad_count, checks;

	aec_host host_u (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
		.reg_addr_o(reg_addr), .reg_rd_o(reg_rd));

	aec_status_counters dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.reg_addr_i(reg_addr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
		.loopback_deactivate_detect_i(deact), .loopback_activate_detect_i(act),
		.driver_short_flag_i(short_flag), .transmit_frame_loss_i(tx_lof),
		.auxiliary_reference_clock_i(aux_clk), .transmit_line_clock_i(tx_clk),
		.basic_frame_alignment_loss_i(basic), .multiframe_alignment_loss_i(mfl),
		.cas_alignment_loss_i(casl), .frame_loss_cause_i(cause), .cas_enable_i(cas_en),
		.mfas_enable_i(mfas_en), .receive_mode_i(mode), .frame_bit_check_i(fb_chk),
		.frame_bit_error_i(fb_err), .ts16_bit_valid_i(ts_vld), .ts16_bit_i(ts_bit),
		.multiframe_start_i(mf_start), .framing_error_i(fe_ev), .crc_error_i(crc_ev),
		.bipolar_violation_i(bpv_ev), .excess_zeros_i(exz_ev),
		.excess_zeros_count_en_i(exz_en), .far_block_error_i(far_block_error_count_ev), .e1_mode_i(e1),
		.counter_overflow_enables_i(ovf_en), .count_latch_enable_i(latch_en),
		.one_second_tick_i(tick), .transmit_alarm_interrupt_status_o(tx_int),
		.receive_alarm_interrupt_status_o(rx_int), .frame_loss_count_inc_o(lof_inc),
		.severely_errored_count_inc_o(sef_inc));

	// ----------------------------------------
	// Clocks: core, auxiliary reference, transmit line
	// ----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	initial begin
		aux_clk = 1'b0;
		#11;
		forever #700 aux_clk = ~aux_clk;
	end
	initial begin
		tx_clk = 1'b0;
		#3;
		forever #130 if (tx_run) tx_clk = ~tx_clk;
	end

	// ----------------------------------------
	// Compare, report and helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out

	function automatic logic [7:0] pv(input int s);
		case (s)
			0: return {3'h0, tx_int};
			1: return {6'h00, rx_int, lof_inc};
			default: return {7'h00, sef_inc};
		endcase
	endfunction : pv

	// Pulse must appear within a few cycles and last exactly one
	task automatic pchk(input int s, input logic [7:0] e);
		for (int i = 0; i < 4 && pv(s) === 8'h00; i++) @(negedge core_clk_i);
		chk(pv(s), e);
		@(negedge core_clk_i);
		chk(pv(s), 8'h00);
	endtask : pchk

	task automatic rr(input logic [8:0] a, input logic [7:0] e);
		host_u.rd8(a, d8);
		chk(d8, e);
	endtask : rr

	task automatic rc(input logic [8:0] a, input logic [15:0] e);
		host_u.rd16(a, d16);
		chk(d16, e);
	endtask : rc

	task automatic pump(input int k, input int n);
		repeat (n) begin
			@(negedge core_clk_i);
			{fe_ev, crc_ev, bpv_ev, exz_ev, far_block_error_count_ev} = 5'h10 >> k;
		end
		@(negedge core_clk_i);
		{fe_ev, crc_ev, bpv_ev, exz_ev, far_block_error_count_ev} = 5'h00;
	endtask : pump

	task automatic fb(input logic [15:0] p, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge core_clk_i);
			fb_chk = 1'b1;
			fb_err = p[i];
		end
		@(negedge core_clk_i);
		fb_chk = 1'b0;
		fb_err = 1'b0;
	endtask : fb

	// One multiframe of TS16 bits with z zeros, closed by a boundary
	task automatic mf(input int z);
		for (int i = 0; i < 128; i++) begin
			@(negedge core_clk_i);
			ts_vld = 1'b1;
			ts_bit = (i >= z);
		end
		@(negedge core_clk_i);
		ts_vld   = 1'b0;
		mf_start = 1'b1;
		@(negedge core_clk_i);
		mf_start = 1'b0;
	endtask : mf

	initial begin
		#1000000;
		bad_count++;
		close_out();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	logic [7:0] ib [4] = '{8'h10, 8'h08, 8'h04, 8'h01};
	logic [7:0] rb [4] = '{8'h80, 8'h40, 8'h10, 8'h02};

	initial begin
		{deact, act, short_flag, tx_lof, basic, mfl, casl, cas_en, mfas_en} = 9'h000;
		{fb_chk, fb_err, ts_vld, ts_bit, mf_start, e1, latch_en, tick} = 8'h00;
		{fe_ev, crc_ev, bpv_ev, exz_ev, far_block_error_count_ev, exz_en} = 6'h00;
		{cause, ovf_en} = 6'h00;
		mode      = aec_pkg::AEC_MODE_E1;
		tx_run    = 1'b1;
		rst_b_i   = 1'b0;
		bad_count = 0;
		checks    = 0;
		repeat (3) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_b_i = 1'b1;
		// Reset values, unmapped holes read zero
		for (int a = 'h48; a <= 'h56; a++) rr(a[8:0], 8'h00);
		// Transmit alarms: both edges raise interrupt, level readable
		@(negedge core_clk_i);
		for (int i = 0; i < 4; i++) begin
			{deact, act, short_flag, tx_lof} = 4'h8 >> i;
			pchk(0, ib[i]);
			rr(aec_pkg::ADDR_TX_ALARM, rb[i]);
			{deact, act, short_flag, tx_lof} = 4'h0;
			pchk(0, ib[i]);
		end
		// Receive alignment bits, gating, cause code, interrupts
		mfas_en = 1'b1;
		cause   = 2'h2;
		basic   = 1'b1;
		pchk(1, 8'h03);
		cause = 2'h0;
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h06);
		{mfl, casl} = 2'h3;
		pchk(1, 8'h00);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h0E);
		cas_en = 1'b1;
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h1E);
		mfas_en = 1'b0;
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h16);
		{basic, mfl, casl, cas_en} = 4'h0;
		pchk(1, 8'h02);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h02);
		latch_en = 1'b1;
		tick     = 1'b1;
		@(negedge core_clk_i);
		tick  = 1'b0;
		cause = 2'h3;
		basic = 1'b1;
		pchk(1, 8'h03);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h07);
		basic = 1'b0;
		pchk(1, 8'h02);
		// Severely errored frame windows per mode
		fb(16'h0005, 3);
		pchk(2, 8'h01);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h23);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h03);
		mode = aec_pkg::AEC_MODE_FT;
		fb(16'h0048, 7);
		pchk(2, 8'h00);
		fb(16'h0001, 1);
		pchk(2, 8'h01);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h23);
		mode = aec_pkg::AEC_MODE_ESF;
		fb(16'h1040, 13);
		pchk(2, 8'h00);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h03);
		// TS16 alarm: four zeros never, three zeros twice latches
		cas_en = 1'b1;
		mf(4);
		mf(4);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h03);
		mf(3);
		mf(3);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h43);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h03);
		cas_en = 1'b0;
		mf(0);
		mf(0);
		rr(aec_pkg::ADDR_RX_ALIGN, 8'h03);
		// Counters: clear on high read, saturate, wrap
		latch_en = 1'b0;
		pump(0, 5);
		rc(aec_pkg::ADDR_FE_LOW, 16'h0005);
		rc(aec_pkg::ADDR_FE_LOW, 16'h0000);
		pump(1, 1025);
		rc(aec_pkg::ADDR_CRC_LOW, 16'h03FF);
		ovf_en = 4'h2;
		pump(1, 1025);
		rc(aec_pkg::ADDR_CRC_LOW, 16'h0001);
		pump(2, 3);
		pump(3, 2);
		exz_en = 1'b1;
		pump(3, 2);
		rc(aec_pkg::ADDR_LCV_LOW, 16'h0005);
		e1 = 1'b1;
		pump(4, 7);
		rr(aec_pkg::ADDR_FAR_BLOCK_ERROR_COUNT_LOW, 8'h07);
		// Latched counts survive reads, live count cleared at the tick
		latch_en = 1'b1;
		pump(0, 4);
		tick = 1'b1;
		@(negedge core_clk_i);
		tick = 1'b0;
		pump(0, 2);
		rc(aec_pkg::ADDR_FE_LOW, 16'h0004);
		rc(aec_pkg::ADDR_FE_LOW, 16'h0004);
		latch_en = 1'b0;
		rc(aec_pkg::ADDR_FE_LOW, 16'h0002);
		rc(aec_pkg::ADDR_FE_LOW, 16'h0000);
		// Transmit clock monitor
		tx_run = 1'b0;
		repeat (600) @(negedge core_clk_i);
		rr(aec_pkg::ADDR_TX_ALARM, 8'h08);
		tx_run = 1'b1;
		repeat (600) @(negedge core_clk_i);
		rr(aec_pkg::ADDR_TX_ALARM, 8'h00);
		close_out();
	end
endmodule : tb
